// [include/rtcops_pkg.sv]
// Package with register map, field positions, reset values and keys of the clock output and protection block.
package rtcops_pkg;
	// ==========================================================================
	// Register byte offsets
	localparam logic [7:0] TIME_OFS = 8'h00;
	localparam logic [7:0] DATE_OFS = 8'h04;
	localparam logic [7:0] CTRL_OFS = 8'h08;
	localparam logic [7:0] ISR_OFS = 8'h0C;
	localparam logic [7:0] PRESC_OFS = 8'h10;
	localparam logic [7:0] KEY_OFS = 8'h24;
	// ==========================================================================
	// Control register fields
	localparam int CTRL_BYPASS_BIT = 5;
	localparam int CTRL_CAL_SRC_BIT = 19;
	localparam int CTRL_POL_BIT = 20;
	localparam int CTRL_ALM_SRC_LSB = 21;
	localparam int CTRL_CAL_EN_BIT = 23;
	localparam logic [31:0] CTRL_MASK = 32'h00F80020;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	// ==========================================================================
	// Interrupt status register fields
	localparam int ISR_CAL_SET_BIT = 4;
	localparam int ISR_SYNCED_BIT = 5;
	localparam int ISR_INIT_ACT_BIT = 6;
	localparam int ISR_INIT_BIT = 7;
	localparam int ISR_ALRA_BIT = 8;
	localparam int ISR_ALRB_BIT = 9;
	localparam int ISR_WUT_BIT = 10;
	// ==========================================================================
	// Prescaler register fields
	localparam int PRESC_ASYNC_LSB = 16;
	localparam int ASYNC_CAL_TAP = 4;
	localparam int ASYNC_CAL_EN_BIT = 5;
	localparam logic [6:0] ASYNC_RESET = 7'h7F;
	localparam logic [14:0] SYNC_RESET = 15'h00FF;
	// ==========================================================================
	// Calendar fields
	localparam int DATE_YEAR_LSB = 16;
	localparam logic [7:0] YEAR_POR = 8'h00;
	localparam logic [31:0] TIME_POR = 32'h00000000;
	localparam logic [31:0] DATE_POR = 32'h00002101;
	// ==========================================================================
	// Unlock keys
	localparam logic [7:0] KEY_FIRST = 8'hCA;
	localparam logic [7:0] KEY_SECOND = 8'h53;
	// ==========================================================================
	// Alarm output source codes
	localparam logic [1:0] ASRC_OFF = 2'h0;
	localparam logic [1:0] ASRC_ALRA = 2'h1;
	localparam logic [1:0] ASRC_ALRB = 2'h2;
	localparam logic [1:0] ASRC_WUT = 2'h3;
	// ==========================================================================
	// Types
	typedef enum logic [1:0] {RTCOPS_LOCKED, RTCOPS_KEY1, RTCOPS_OPEN} rtcops_key_t;
endpackage : rtcops_pkg

// [hw/rtcops_alarm_mux.sv]
// Alarm output pin multiplexer with polarity.
module rtcops_alarm_mux (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [1:0] alarm_out_source,
	input wire logic polarity_low,
	input wire logic alarm_a_flag,
	input wire logic alarm_b_flag,
	input wire logic wakeup_flag,
	output logic alarm_out
);
	logic sel_flag;

	// ==========================================================================
	// Source selection
	always_comb begin
		case (alarm_out_source)
			rtcops_pkg::ASRC_ALRA: sel_flag = alarm_a_flag;
			rtcops_pkg::ASRC_ALRB: sel_flag = alarm_b_flag;
			rtcops_pkg::ASRC_WUT: sel_flag = wakeup_flag;
			default: sel_flag = 1'b0;
		endcase
	end

	// The pin idles at the inactive level when no source is chosen.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alarm_out <= 1'b0;
		end else begin
			alarm_out <= sel_flag ^ polarity_low;
		end
	end

	property p_alarm_level;
		@(posedge hclk) disable iff (!hresetn)
		(alarm_out_source != rtcops_pkg::ASRC_OFF) |=> (alarm_out == ($past(sel_flag) ^ $past(polarity_low)));
	endproperty
	a_alarm_level: assert property (p_alarm_level) else $error("alarm pin does not follow selected flag");

	property p_wakeup_hold;
		@(posedge hclk) disable iff (!hresetn)
		(alarm_out_source == rtcops_pkg::ASRC_WUT && wakeup_flag && !polarity_low) [*2] |=> alarm_out;
	endproperty
	a_wakeup_hold: assert property (p_wakeup_hold) else $error("alarm pin dropped while wakeup flag set");
endmodule : rtcops_alarm_mux

// [hw/rtcops_top.sv]
// Clock output, alarm pin, write protection, init mode and shadow synchronisation block with an AHB-Lite slave.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.

// Contract
// - Calibration pin comes from async counter bit four
// - No calibration output when divider bit five clear
// - Async divider sets calibration division factor
// - Enable gates output; select picks tap or second
// - Second tick from async then sync prescaler
// - Alarm match sets its alarm flag
// - Source field routes alarm or wakeup flag
// - Pin active while selected flag set
// - Wakeup counter zero sets wakeup flag
// - Wakeup source holds pin until flag cleared
// - Protected registers locked after reset
// - Keys 0xCA then 0x53 unlock writes
// - Wrong key relocks protected registers
// - Init mode halts calendar; resumes from written values
// - Calendar and prescaler writable only in init
// - Clearing init request restarts counting
// - Calendar reset only by power-on reset
// - Calendar set flag shows nonzero year
// - Shadows copied every two kernel cycles, flag set
// - Bypass reads return live calendar values
module rtcops_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic poresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic kernel_clock,
	input wire logic alarm_a_match,
	input wire logic alarm_b_match,
	input wire logic wakeup_zero,
	output logic cal_out,
	output logic alarm_out
);
	logic kclk_d_reg;
	logic ktick;
	logic [6:0] async_cnt_reg;
	logic [14:0] sync_cnt_reg;
	logic async_wrap;
	logic sec_tick;
	logic half_tick_reg;
	logic [31:0] time_reg;
	logic [31:0] date_reg;
	logic [31:0] control_reg;
	logic [6:0] async_divider;
	logic [14:0] sync_divider;
	logic [31:0] time_shadow_reg;
	logic [31:0] date_shadow_reg;
	logic shadow_synced_flag;
	logic alarm_a_flag;
	logic alarm_b_flag;
	logic wakeup_flag;
	logic init_req_reg;
	logic init_active_flag;
	logic calendar_set_flag;
	rtcops_pkg::rtcops_key_t key_state_reg;
	logic unlocked;
	logic wr_v_reg;
	logic [7:0] wr_addr_reg;
	logic addr_ph;
	logic wr;
	logic wr_key;
	logic wr_isr;
	logic wr_prot;
	logic wr_cal;
	logic shadow_copy;
	logic [31:0] isr_view;
	logic [31:0] rd_next;
	logic shadow_bypass;
	logic cal_out_next;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign shadow_bypass = control_reg[rtcops_pkg::CTRL_BYPASS_BIT];
	assign unlocked = (key_state_reg == rtcops_pkg::RTCOPS_OPEN);
	assign calendar_set_flag = (date_reg[rtcops_pkg::DATE_YEAR_LSB +: 8] != rtcops_pkg::YEAR_POR);

	// ==========================================================================
	// AHB-Lite slave: zero wait states, reads captured in the address phase
	assign addr_ph = hsel && htrans[1] && hready;
	assign wr = wr_v_reg;
	assign wr_key = wr && (wr_addr_reg == rtcops_pkg::KEY_OFS);
	assign wr_isr = wr && (wr_addr_reg == rtcops_pkg::ISR_OFS);
	assign wr_prot = wr && unlocked;
	assign wr_cal = wr_prot && init_active_flag;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_v_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end else begin
			wr_v_reg <= addr_ph && hwrite;
			wr_addr_reg <= {haddr[7:2], 2'b00};
		end
	end

	always_comb begin
		isr_view = 32'h00000000;
		isr_view[rtcops_pkg::ISR_CAL_SET_BIT] = calendar_set_flag;
		isr_view[rtcops_pkg::ISR_SYNCED_BIT] = shadow_synced_flag;
		isr_view[rtcops_pkg::ISR_INIT_ACT_BIT] = init_active_flag;
		isr_view[rtcops_pkg::ISR_INIT_BIT] = init_req_reg;
		isr_view[rtcops_pkg::ISR_ALRA_BIT] = alarm_a_flag;
		isr_view[rtcops_pkg::ISR_ALRB_BIT] = alarm_b_flag;
		isr_view[rtcops_pkg::ISR_WUT_BIT] = wakeup_flag;
	end

	always_comb begin
		case ({haddr[7:2], 2'b00})
			rtcops_pkg::TIME_OFS: rd_next = shadow_bypass ? time_reg : time_shadow_reg;
			rtcops_pkg::DATE_OFS: rd_next = shadow_bypass ? date_reg : date_shadow_reg;
			rtcops_pkg::CTRL_OFS: rd_next = control_reg;
			rtcops_pkg::ISR_OFS: rd_next = isr_view;
			rtcops_pkg::PRESC_OFS: rd_next = {9'h000, async_divider, 1'b0, sync_divider};
			default: rd_next = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (addr_ph && !hwrite) begin
			hrdata <= rd_next;
		end
	end

	// ==========================================================================
	// Write key sequence
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			key_state_reg <= rtcops_pkg::RTCOPS_LOCKED;
		end else if (wr_key) begin
			case (key_state_reg)
				rtcops_pkg::RTCOPS_KEY1: begin
					if (hwdata[7:0] == rtcops_pkg::KEY_SECOND) begin
						key_state_reg <= rtcops_pkg::RTCOPS_OPEN;
					end else if (hwdata[7:0] == rtcops_pkg::KEY_FIRST) begin
						key_state_reg <= rtcops_pkg::RTCOPS_KEY1;
					end else begin
						key_state_reg <= rtcops_pkg::RTCOPS_LOCKED;
					end
				end
				default: begin
					if (hwdata[7:0] == rtcops_pkg::KEY_FIRST) begin
						key_state_reg <= rtcops_pkg::RTCOPS_KEY1;
					end else begin
						key_state_reg <= rtcops_pkg::RTCOPS_LOCKED;
					end
				end
			endcase
		end
	end

	// ==========================================================================
	// Kernel clock edge detect and prescalers, halted in init mode
	assign ktick = kernel_clock && !kclk_d_reg;
	assign async_wrap = ktick && (async_cnt_reg == 7'h00);
	assign sec_tick = async_wrap && (sync_cnt_reg == 15'h0000);

	always_ff @(posedge hclk or negedge poresetn) begin
		if (!poresetn) begin
			kclk_d_reg <= 1'b0;
		end else begin
			kclk_d_reg <= kernel_clock;
		end
	end

	// A write to the prescaler register restarts both counters from the new values.
	always_ff @(posedge hclk or negedge poresetn) begin
		if (!poresetn) begin
			async_cnt_reg <= rtcops_pkg::ASYNC_RESET;
			sync_cnt_reg <= rtcops_pkg::SYNC_RESET;
		end else if (wr_cal && wr_addr_reg == rtcops_pkg::PRESC_OFS) begin
			async_cnt_reg <= hwdata[rtcops_pkg::PRESC_ASYNC_LSB +: 7];
			sync_cnt_reg <= hwdata[14:0];
		end else if (ktick && !init_active_flag) begin
			if (async_wrap) begin
				async_cnt_reg <= async_divider;
				sync_cnt_reg <= (sync_cnt_reg == 15'h0000) ? sync_divider : sync_cnt_reg - 15'h0001;
			end else begin
				async_cnt_reg <= async_cnt_reg - 7'h01;
			end
		end
	end

	// ==========================================================================
	// Power-on domain registers: calendar, control and prescaler settings
	always_ff @(posedge hclk or negedge poresetn) begin
		if (!poresetn) begin
			async_divider <= rtcops_pkg::ASYNC_RESET;
			sync_divider <= rtcops_pkg::SYNC_RESET;
		end else if (wr_cal && wr_addr_reg == rtcops_pkg::PRESC_OFS) begin
			async_divider <= hwdata[rtcops_pkg::PRESC_ASYNC_LSB +: 7];
			sync_divider <= hwdata[14:0];
		end
	end

	always_ff @(posedge hclk or negedge poresetn) begin
		if (!poresetn) begin
			control_reg <= rtcops_pkg::CTRL_RESET;
		end else if (wr_prot && wr_addr_reg == rtcops_pkg::CTRL_OFS) begin
			control_reg <= hwdata & rtcops_pkg::CTRL_MASK;
		end
	end

	// The calendar sits on the power-on reset so a system reset leaves it running.
	always_ff @(posedge hclk or negedge poresetn) begin
		if (!poresetn) begin
			time_reg <= rtcops_pkg::TIME_POR;
			date_reg <= rtcops_pkg::DATE_POR;
		end else begin
			if (wr_cal && wr_addr_reg == rtcops_pkg::TIME_OFS) begin
				time_reg <= hwdata;
			end else if (sec_tick && !init_active_flag) begin
				time_reg <= time_reg + 32'h00000001;
			end
			if (wr_cal && wr_addr_reg == rtcops_pkg::DATE_OFS) begin
				date_reg <= hwdata;
			end
		end
	end

	// ==========================================================================
	// Init mode request and acknowledge on a kernel edge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_req_reg <= 1'b0;
			init_active_flag <= 1'b0;
		end else begin
			if (wr_isr && unlocked) begin
				init_req_reg <= hwdata[rtcops_pkg::ISR_INIT_BIT];
			end
			if (ktick) begin
				init_active_flag <= init_req_reg;
			end
		end
	end

	// ==========================================================================
	// Shadow copies every second kernel edge
	assign shadow_copy = ktick && half_tick_reg && !init_active_flag;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			half_tick_reg <= 1'b0;
			time_shadow_reg <= 32'h00000000;
			date_shadow_reg <= 32'h00000000;
		end else begin
			if (ktick) begin
				half_tick_reg <= !half_tick_reg;
			end
			if (shadow_copy) begin
				time_shadow_reg <= time_reg;
				date_shadow_reg <= date_reg;
			end
		end
	end

	// ==========================================================================
	// Event flags: hardware set wins over a software write of zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			shadow_synced_flag <= 1'b0;
			alarm_a_flag <= 1'b0;
			alarm_b_flag <= 1'b0;
			wakeup_flag <= 1'b0;
		end else begin
			if (shadow_copy) begin
				shadow_synced_flag <= 1'b1;
			end else if (wr_isr && !hwdata[rtcops_pkg::ISR_SYNCED_BIT]) begin
				shadow_synced_flag <= 1'b0;
			end
			if (alarm_a_match) begin
				alarm_a_flag <= 1'b1;
			end else if (wr_isr && !hwdata[rtcops_pkg::ISR_ALRA_BIT]) begin
				alarm_a_flag <= 1'b0;
			end
			if (alarm_b_match) begin
				alarm_b_flag <= 1'b1;
			end else if (wr_isr && !hwdata[rtcops_pkg::ISR_ALRB_BIT]) begin
				alarm_b_flag <= 1'b0;
			end
			if (wakeup_zero) begin
				wakeup_flag <= 1'b1;
			end else if (wr_isr && !hwdata[rtcops_pkg::ISR_WUT_BIT]) begin
				wakeup_flag <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// Calibration output
	always_comb begin
		if (!control_reg[rtcops_pkg::CTRL_CAL_EN_BIT] || !async_divider[rtcops_pkg::ASYNC_CAL_EN_BIT]) begin
			cal_out_next = 1'b0;
		end else if (control_reg[rtcops_pkg::CTRL_CAL_SRC_BIT]) begin
			cal_out_next = (sync_cnt_reg == 15'h0000);
		end else begin
			cal_out_next = async_cnt_reg[rtcops_pkg::ASYNC_CAL_TAP];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_out <= 1'b0;
		end else begin
			cal_out <= cal_out_next;
		end
	end

	rtcops_alarm_mux i_rtcops_alarm_mux (
		.hclk(hclk),
		.hresetn(hresetn),
		.alarm_out_source(control_reg[rtcops_pkg::CTRL_ALM_SRC_LSB +: 2]),
		.polarity_low(control_reg[rtcops_pkg::CTRL_POL_BIT]),
		.alarm_a_flag(alarm_a_flag),
		.alarm_b_flag(alarm_b_flag),
		.wakeup_flag(wakeup_flag),
		.alarm_out(alarm_out)
	);

	// ==========================================================================
	// Checks
	property p_cal_off;
		@(posedge hclk) disable iff (!hresetn)
		!async_divider[rtcops_pkg::ASYNC_CAL_EN_BIT] |=> !cal_out;
	endproperty
	a_cal_off: assert property (p_cal_off) else $error("calibration pin active with divider bit five clear");

	property p_cal_tap;
		@(posedge hclk) disable iff (!hresetn)
		(control_reg[rtcops_pkg::CTRL_CAL_EN_BIT] && !control_reg[rtcops_pkg::CTRL_CAL_SRC_BIT]
			&& async_divider[rtcops_pkg::ASYNC_CAL_EN_BIT])
			|=> (cal_out == $past(async_cnt_reg[rtcops_pkg::ASYNC_CAL_TAP]));
	endproperty
	a_cal_tap: assert property (p_cal_tap) else $error("calibration pin not on counter bit four");

	property p_locked_time;
		@(posedge hclk) disable iff (!hresetn || !poresetn)
		(wr && wr_addr_reg == rtcops_pkg::TIME_OFS && !wr_cal && !sec_tick) |=> $stable(time_reg);
	endproperty
	a_locked_time: assert property (p_locked_time) else $error("locked time register was written");

	property p_key_open;
		@(posedge hclk) disable iff (!hresetn)
		(wr_key && key_state_reg == rtcops_pkg::RTCOPS_KEY1 && hwdata[7:0] == rtcops_pkg::KEY_SECOND) |=> unlocked;
	endproperty
	a_key_open: assert property (p_key_open) else $error("key sequence did not unlock");

	property p_key_bad;
		@(posedge hclk) disable iff (!hresetn)
		(wr_key && hwdata[7:0] != rtcops_pkg::KEY_FIRST && hwdata[7:0] != rtcops_pkg::KEY_SECOND) |=> !unlocked;
	endproperty
	a_key_bad: assert property (p_key_bad) else $error("wrong key left registers open");

	property p_halt;
		@(posedge hclk) disable iff (!poresetn || !hresetn)
		(init_active_flag && !wr_cal) |=> $stable(time_reg);
	endproperty
	a_halt: assert property (p_halt) else $error("calendar moved in init mode");

	property p_init_active_flag;
		@(posedge hclk) disable iff (!hresetn)
		(init_req_reg && ktick) |=> init_active_flag;
	endproperty
	a_init_active_flag: assert property (p_init_active_flag) else $error("init active flag not raised");

	property p_rsf;
		@(posedge hclk) disable iff (!hresetn)
		shadow_copy |=> (shadow_synced_flag && time_shadow_reg == $past(time_reg));
	endproperty
	a_rsf: assert property (p_rsf) else $error("shadow copy or synced flag missing");

	property p_bypass;
		@(posedge hclk) disable iff (!hresetn)
		(addr_ph && !hwrite && haddr[7:0] == rtcops_pkg::TIME_OFS && shadow_bypass) |=> (hrdata == $past(time_reg));
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass read did not return live time");

	property p_alarm_set;
		@(posedge hclk) disable iff (!hresetn)
		alarm_a_match |=> alarm_a_flag ##1 (alarm_out || control_reg[rtcops_pkg::CTRL_POL_BIT]
			|| control_reg[rtcops_pkg::CTRL_ALM_SRC_LSB +: 2] != rtcops_pkg::ASRC_ALRA);
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm match did not set flag or pin");

	property p_rsf_clear;
		@(posedge hclk) disable iff (!hresetn)
		(wr_isr && !hwdata[rtcops_pkg::ISR_SYNCED_BIT] && hwdata[rtcops_pkg::ISR_ALRA_BIT]
			&& !shadow_copy && !alarm_a_match)
			|=> (!shadow_synced_flag && alarm_a_flag == $past(alarm_a_flag));
	endproperty
	a_rsf_clear: assert property (p_rsf_clear) else $error("synced flag clear disturbed other bits");
endmodule : rtcops_top

// [sim/rtc_outputs_protect_sync_tb.sv]
// Self-checking testbench of the clock output, alarm pin, protection, init and shadow block.
module rtc_outputs_protect_sync_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] A_TIME = {24'h00, rtcops_pkg::TIME_OFS};
	localparam logic [31:0] A_DATE = {24'h00, rtcops_pkg::DATE_OFS};
	localparam logic [31:0] A_CTRL = {24'h00, rtcops_pkg::CTRL_OFS};
	localparam logic [31:0] A_ISR = {24'h00, rtcops_pkg::ISR_OFS};
	localparam logic [31:0] A_PRE = {24'h00, rtcops_pkg::PRESC_OFS};
	localparam logic [31:0] A_KEY = {24'h00, rtcops_pkg::KEY_OFS};
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic poresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic kernel_clock = 1'b0;
	logic [1:0] kdiv = 2'h0;
	logic [2:0] mt = 3'h0;
	logic cal_out;
	logic alarm_out;
	int errors = 0;
	int num_checks = 0;
	logic [31:0] rd;
	logic [31:0] t0;
	assign hready = hreadyout;
	always #2.5 hclk = ~hclk;
	// ==========================================================================
	// Kernel clock at a quarter of the bus clock.
	always @(posedge hclk) begin
		kdiv <= kdiv + 2'h1;
		kernel_clock <= kdiv[1];
	end
	rtcops_top i_rtcops_top (.hclk(hclk), .hresetn(hresetn), .poresetn(poresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .kernel_clock(kernel_clock), .alarm_a_match(mt[0]), .alarm_b_match(mt[1]),
		.wakeup_zero(mt[2]), .cal_out(cal_out), .alarm_out(alarm_out));
	// ==========================================================================
	// Bus and check helpers
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		num_checks++;
		if (!(got >= lo && got <= hi)) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_rng
	task automatic pin(input logic v);
		chk({31'h0, alarm_out}, {31'h0, v});
	endtask : pin
	task automatic pulse(input int k);
		@(posedge hclk);
		mt[k] <= 1'b1;
		@(posedge hclk);
		mt[k] <= 1'b0;
		repeat (3) @(posedge hclk);
	endtask : pulse
	task automatic unlock();
		ahb(1'b1, A_KEY, 32'h000000CA);
		ahb(1'b1, A_KEY, 32'h00000053);
	endtask : unlock
	task automatic wait_isr(input int b, input logic v);
		for (int i = 0; i < 100; i++) begin
			ahb(1'b0, A_ISR, 32'h0);
			if (rd[b] === v) break;
		end
		chk({31'h0, rd[b]}, {31'h0, v});
	endtask : wait_isr
	task automatic init_on();
		ahb(1'b1, A_ISR, 32'h000007A0);
		wait_isr(rtcops_pkg::ISR_INIT_ACT_BIT, 1'b1);
	endtask : init_on
	task automatic init_off();
		ahb(1'b1, A_ISR, 32'h00000720);
		wait_isr(rtcops_pkg::ISR_INIT_ACT_BIT, 1'b0);
	endtask : init_off
	// ==========================================================================
	// Scenarios
	task automatic t_reset_and_lock();
		ahb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'h00000000);
		ahb(1'b0, A_PRE, 32'h0);
		chk(rd, 32'h007F00FF);
		ahb(1'b0, A_ISR, 32'h0);
		chk({31'h0, rd[rtcops_pkg::ISR_CAL_SET_BIT]}, 32'h0);
		ahb(1'b0, 32'h00000040, 32'h0);
		chk(rd, 32'h00000000);
		chk({31'h0, hresp}, 32'h0);
		ahb(1'b1, A_CTRL, 32'h00000020);
		ahb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'h00000000);
		unlock();
		ahb(1'b1, A_CTRL, 32'h00000020);
		ahb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'h00000020);
		ahb(1'b1, A_KEY, 32'h000000CA);
		ahb(1'b1, A_KEY, 32'h00000011);
		ahb(1'b1, A_CTRL, 32'h00000000);
		ahb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'h00000020);
		unlock();
	endtask : t_reset_and_lock
	task automatic t_init_calendar();
		ahb(1'b1, A_TIME, 32'h00000055);
		ahb(1'b0, A_TIME, 32'h0);
		chk(rd, 32'h00000000);
		init_on();
		ahb(1'b1, A_TIME, 32'h00000010);
		ahb(1'b1, A_DATE, 32'h00242101);
		ahb(1'b1, A_PRE, 32'h00210001);
		repeat (600) @(posedge hclk);
		ahb(1'b0, A_TIME, 32'h0);
		chk(rd, 32'h00000010);
		ahb(1'b0, A_ISR, 32'h0);
		chk({31'h0, rd[rtcops_pkg::ISR_CAL_SET_BIT]}, 32'h1);
		init_off();
		repeat (700) @(posedge hclk);
		ahb(1'b0, A_TIME, 32'h0);
		t0 = rd;
		ahb(1'b0, A_TIME, 32'h0);
		if (rd !== t0) begin
			ahb(1'b0, A_TIME, 32'h0);
		end
		chk_rng(rd, 32'h00000011, 32'h00000014);
		t0 = rd;
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(1'b0, A_TIME, 32'h0);
		chk_rng(rd, t0, t0 + 32'h1);
		ahb(1'b1, A_CTRL, 32'h00000000);
		ahb(1'b0, A_CTRL, 32'h0);
		chk(rd, 32'h00000020);
		unlock();
	endtask : t_init_calendar
	task automatic t_shadow();
		ahb(1'b1, A_CTRL, 32'h00000000);
		ahb(1'b1, A_ISR, 32'h00000000);
		wait_isr(rtcops_pkg::ISR_SYNCED_BIT, 1'b1);
		ahb(1'b0, A_TIME, 32'h0);
		chk_rng(rd, t0, t0 + 32'h2);
		pulse(0);
		ahb(1'b1, A_ISR, 32'h00000700);
		ahb(1'b0, A_ISR, 32'h0);
		chk({31'h0, rd[rtcops_pkg::ISR_ALRA_BIT]}, 32'h1);
	endtask : t_shadow
	task automatic t_alarm_pin();
		for (int s = 1; s <= 3; s++) begin
			ahb(1'b1, A_ISR, 32'h00000020);
			ahb(1'b1, A_CTRL, 32'(s) << rtcops_pkg::CTRL_ALM_SRC_LSB);
			pulse(s % 3);
			pin(1'b0);
			pulse(s - 1);
			repeat (50) @(posedge hclk);
			pin(1'b1);
			ahb(1'b1, A_ISR, 32'h00000720 & ~(32'h1 << (7 + s)));
			repeat (2) @(posedge hclk);
			pin(1'b0);
		end
		ahb(1'b1, A_ISR, 32'h00000020);
		ahb(1'b1, A_CTRL, 32'h00300000);
		repeat (2) @(posedge hclk);
		pin(1'b1);
		pulse(0);
		pin(1'b0);
		ahb(1'b1, A_ISR, 32'h00000620);
		repeat (2) @(posedge hclk);
		pin(1'b1);
		ahb(1'b1, A_CTRL, 32'h00000000);
		pulse(0);
		pin(1'b0);
	endtask : t_alarm_pin
	task automatic t_cal_out();
		logic [31:0] pre[5] = '{32'h00210001, 32'h003F0001, 32'h001F0001, 32'h00210001, 32'h00210001};
		logic [31:0] ctl[5] = '{32'h00800000, 32'h00800000, 32'h00800000, 32'h00880000, 32'h00000000};
		int win[5] = '{1360, 2560, 2560, 2720, 1360};
		logic [31:0] lo[5] = '{32'h9, 32'h13, 32'h0, 32'h9, 32'h0};
		logic [31:0] hi[5] = '{32'hB, 32'h15, 32'h0, 32'hB, 32'h0};
		logic prev;
		int n;
		for (int k = 0; k < 5; k++) begin
			init_on();
			ahb(1'b1, A_PRE, pre[k]);
			ahb(1'b1, A_CTRL, ctl[k]);
			init_off();
			n = 0;
			prev = cal_out;
			repeat (win[k]) begin
				@(posedge hclk);
				if (cal_out === 1'b1 && prev === 1'b0) n++;
				prev = cal_out;
			end
			chk_rng(32'(n), lo[k], hi[k]);
		end
	endtask : t_cal_out
	// ==========================================================================
	// Run control
	task automatic summarize();
		$display("checks=%0d errors=%0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		poresetn <= 1'b1;
		t_reset_and_lock();
		t_init_calendar();
		t_shadow();
		t_alarm_pin();
		t_cal_out();
		summarize();
	end
	initial begin
		repeat (60000) @(posedge hclk);
		errors++;
		summarize();
	end
endmodule : rtc_outputs_protect_sync_tb
